/* timer_event_counter_time_base_defs.svh */
`ifndef TIMER_EVENT_COUNTER_TIME_BASE_DEFS_SVH
`define TIMER_EVENT_COUNTER_TIME_BASE_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_COUNTER0_CONTROL 8'h00
`define ADDR_COUNTER0_PRELOAD 8'h01
`define ADDR_INTERRUPT_CONTROL_ZERO 8'h02
`define ADDR_SYSTEM_CONTROL_ONE 8'h03

// ****************************************************************
// Field positions and encodings
// ****************************************************************
`define MODE_EVENT 2'b01
`define MODE_TIMER 2'b10
`define MODE_CAPTURE 2'b11
`define INTC_CNT_EN_BIT 0
`define INTC_CNT_FLAG_BIT 1
`define INTC_TB_EN_BIT 2
`define INTC_TB_FLAG_BIT 3
`define SYSCTL_SEL_LO_BIT 0
`define SYSCTL_SEL_HI_BIT 1

// ****************************************************************
// Reset values, vectors and timing counts
// ****************************************************************
`define RST_COUNTER0_CONTROL 8'h00
`define RST_COUNTER0_PRELOAD 8'h00
`define RST_INTERRUPT_CONTROL 4'h0
`define RST_INTERVAL_SELECT 2'h0
`define COUNTER0_VECTOR 8'h08
`define TB_BASE_STAGES 4'ha
`define TB_STAGES 13

`endif

/* timer_event_counter_time_base_pkg.sv */
package timer_event_counter_time_base_pkg;

  // Layout of the counter0_control register, bit 7 first.
  typedef struct packed {
    logic [1:0] operating_mode_select;
    logic counter0_clock_source_select;
    logic counter_run_bit;
    logic active_edge_select;
    logic [2:0] prescale_select;
  } counter0_control_t;

  // Layout of the interrupt_control_zero register, bit 3 first.
  typedef struct packed {
    logic tb_flag;
    logic tb_enable;
    logic counter_flag;
    logic counter_enable;
  } interrupt_control_t;

  typedef enum logic [1:0] {
    cap_idle,
    cap_wait,
    cap_count
  } capture_state_t;

endpackage

/* timer_event_counter_time_base.sv */
`include "timer_event_counter_time_base_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_event_counter_time_base #(
  parameter logic [7:0] TB_VECTOR = 8'h0c
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_external_count_pin,
  input wire logic i_pin_pullup_enable,
  input wire logic i_alt_clock_tick,
  input wire logic i_power_down,
  output logic o_pin_pullup,
  output logic o_counter_irq,
  output logic o_tb_irq,
  output logic [7:0] o_vector_addr,
  output logic o_wake,
  output logic o_tb_timeout
);

  // ****************************************************************
  // State
  // ****************************************************************
  timer_event_counter_time_base_pkg::counter0_control_t ctrl_r;
  timer_event_counter_time_base_pkg::counter0_control_t ctrl_nxt;
  timer_event_counter_time_base_pkg::interrupt_control_t intc_r;
  timer_event_counter_time_base_pkg::interrupt_control_t intc_nxt;
  timer_event_counter_time_base_pkg::capture_state_t cap_r;
  timer_event_counter_time_base_pkg::capture_state_t cap_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] preload_r;
  logic [7:0] preload_nxt;
  logic [1:0] interval_r;
  logic [1:0] interval_nxt;
  logic [7:0] psc_r;
  logic [7:0] psc_nxt;
  logic [`TB_STAGES-1:0] tb_r;
  logic [`TB_STAGES-1:0] tb_nxt;
  logic pin_r;
  logic pin_prev_r;
  logic [7:0] rdata_nxt;
  logic pullup_nxt;
  logic counter_irq_nxt;
  logic tb_irq_nxt;
  logic [7:0] vector_nxt;
  logic wake_nxt;
  logic tb_timeout_nxt;

  // ****************************************************************
  // Derived terms
  // ****************************************************************
  logic src_tick;
  logic psc_tick;
  logic [7:0] psc_mask;
  logic [`TB_STAGES-1:0] tb_mask;
  logic [3:0] tb_stages;
  logic pin_rise;
  logic pin_fall;
  logic start_edge;
  logic end_edge;
  logic inhibit;
  logic advance;
  logic overflow;
  logic tb_hit;
  logic wr_ctrl;
  logic wr_preload;
  logic wr_intc;
  logic wr_sys;

  always_comb begin
    // Source select 0 is the system clock itself, 1 is the slower tick.
    src_tick = ctrl_r.counter0_clock_source_select ? i_alt_clock_tick : 1'b1;
    psc_mask = (8'h01 << ctrl_r.prescale_select) - 8'h01;
    psc_tick = src_tick && ((psc_r & psc_mask) == psc_mask);
    tb_stages = `TB_BASE_STAGES + {2'b00, interval_r};
    tb_mask = (`TB_STAGES'(1) << tb_stages) - `TB_STAGES'(1);
    tb_hit = src_tick && ((tb_r & tb_mask) == tb_mask);
    pin_rise = pin_r && !pin_prev_r;
    pin_fall = !pin_r && pin_prev_r;
    // Capture starts on the edge leaving the idle level and stops on the return.
    start_edge = ctrl_r.active_edge_select ? pin_rise : pin_fall;
    end_edge = ctrl_r.active_edge_select ? pin_fall : pin_rise;
    wr_ctrl = i_wr && (i_addr == `ADDR_COUNTER0_CONTROL);
    wr_preload = i_wr && (i_addr == `ADDR_COUNTER0_PRELOAD);
    wr_intc = i_wr && (i_addr == `ADDR_INTERRUPT_CONTROL_ZERO);
    wr_sys = i_wr && (i_addr == `ADDR_SYSTEM_CONTROL_ONE);
    // A count that falls in a read or write of the preload address is dropped rather than corrupting the value read.
    inhibit = wr_preload || (i_rd && (i_addr == `ADDR_COUNTER0_PRELOAD));
    advance = 1'b0;
    case (ctrl_r.operating_mode_select)
      `MODE_TIMER: advance = ctrl_r.counter_run_bit && psc_tick;
      `MODE_EVENT: begin
        // Edge select low counts rising edges, high counts falling edges.
        advance = ctrl_r.counter_run_bit && (ctrl_r.active_edge_select ? pin_fall : pin_rise);
      end
      `MODE_CAPTURE: begin
        // The count only advances on the prescaled tick while in cap_count.
        advance = (cap_r == timer_event_counter_time_base_pkg::cap_count) && psc_tick;
      end
      default: advance = 1'b0;
    endcase
    advance = advance && !inhibit;
    overflow = advance && (count_r == 8'hff);
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    intc_nxt = intc_r;
    cap_nxt = cap_r;
    count_nxt = count_r;
    preload_nxt = preload_r;
    interval_nxt = interval_r;
    psc_nxt = src_tick ? psc_r + 8'h01 : psc_r;
    rdata_nxt = 8'h00;
    wake_nxt = 1'b0;

    if (advance) begin
      count_nxt = overflow ? preload_r : count_r + 8'h01;
    end

    // Capture sequence; leaving capture mode or stopping returns to idle.
    case (cap_r)
      timer_event_counter_time_base_pkg::cap_idle: begin
        if ((ctrl_r.operating_mode_select == `MODE_CAPTURE) && ctrl_r.counter_run_bit) begin
          cap_nxt = timer_event_counter_time_base_pkg::cap_wait;
        end
      end
      timer_event_counter_time_base_pkg::cap_wait: begin
        if (start_edge) begin
          cap_nxt = timer_event_counter_time_base_pkg::cap_count;
        end
      end
      timer_event_counter_time_base_pkg::cap_count: begin
        if (end_edge) begin
          ctrl_nxt.counter_run_bit = 1'b0;
          cap_nxt = timer_event_counter_time_base_pkg::cap_idle;
        end
      end
      default: cap_nxt = timer_event_counter_time_base_pkg::cap_idle;
    endcase
    if ((ctrl_r.operating_mode_select != `MODE_CAPTURE) || !ctrl_r.counter_run_bit) begin
      cap_nxt = timer_event_counter_time_base_pkg::cap_idle;
    end

    // Software writes; a write in the same cycle overrides the automatic stop.
    if (wr_ctrl) begin
      ctrl_nxt = i_wdata;
    end
    if (wr_preload) begin
      preload_nxt = i_wdata;
      if (!ctrl_r.counter_run_bit) begin
        count_nxt = i_wdata;
      end
    end
    if (wr_intc) begin
      intc_nxt = i_wdata[3:0];
    end
    if (wr_sys) begin
      interval_nxt = {i_wdata[`SYSCTL_SEL_HI_BIT], i_wdata[`SYSCTL_SEL_LO_BIT]};
    end

    // Hardware sets win over a software clear in the same cycle.
    if (overflow) begin
      intc_nxt.counter_flag = 1'b1;
      // Wake does not look at the enable, only at i_power_down and at whether the flag was still clear.
      wake_nxt = i_power_down && !intc_r.counter_flag;
    end
    if (tb_hit) begin
      intc_nxt.tb_flag = 1'b1;
    end

    if (i_rd) begin
      case (i_addr)
        `ADDR_COUNTER0_CONTROL: rdata_nxt = ctrl_r;
        `ADDR_COUNTER0_PRELOAD: rdata_nxt = count_r;
        `ADDR_INTERRUPT_CONTROL_ZERO: rdata_nxt = {4'h0, intc_r};
        `ADDR_SYSTEM_CONTROL_ONE: rdata_nxt = {6'h00, interval_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Time base next state
  // ****************************************************************
  always_comb begin
    // The divider advances on every source tick, so every full turn of the selected stages is one timeout.
    tb_nxt = src_tick ? tb_r + `TB_STAGES'(1) : tb_r;
    tb_timeout_nxt = tb_hit;
  end

  // ****************************************************************
  // Output next state
  // ****************************************************************
  always_comb begin
    pullup_nxt = i_pin_pullup_enable;
    counter_irq_nxt = intc_nxt.counter_flag && intc_nxt.counter_enable;
    tb_irq_nxt = intc_nxt.tb_flag && intc_nxt.tb_enable;
    // The counter vector takes priority when both requests stand.
    if (counter_irq_nxt) begin
      vector_nxt = `COUNTER0_VECTOR;
    end else if (tb_irq_nxt) begin
      vector_nxt = TB_VECTOR;
    end else begin
      vector_nxt = 8'h00;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_r <= `RST_COUNTER0_CONTROL;
      intc_r <= `RST_INTERRUPT_CONTROL;
      preload_r <= `RST_COUNTER0_PRELOAD;
      interval_r <= `RST_INTERVAL_SELECT;
    end else begin
      ctrl_r <= ctrl_nxt;
      intc_r <= intc_nxt;
      preload_r <= preload_nxt;
      interval_r <= interval_nxt;
    end
  end

  // ****************************************************************
  // Counter, capture and prescaler registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cap_r <= timer_event_counter_time_base_pkg::cap_idle;
      count_r <= `RST_COUNTER0_PRELOAD;
      psc_r <= 8'h00;
    end else begin
      cap_r <= cap_nxt;
      count_r <= count_nxt;
      psc_r <= psc_nxt;
    end
  end

  // ****************************************************************
  // Time base and pin sample registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tb_r <= '0;
      // A false edge just after reset is harmless, since the run bit is still clear.
      pin_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      tb_r <= tb_nxt;
      pin_r <= i_external_count_pin;
      pin_prev_r <= pin_r;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_pin_pullup <= 1'b0;
      o_counter_irq <= 1'b0;
      o_tb_irq <= 1'b0;
      o_vector_addr <= 8'h00;
      o_wake <= 1'b0;
      o_tb_timeout <= 1'b0;
    end else begin
      o_rdata <= rdata_nxt;
      o_pin_pullup <= pullup_nxt;
      o_counter_irq <= counter_irq_nxt;
      o_tb_irq <= tb_irq_nxt;
      o_vector_addr <= vector_nxt;
      o_wake <= wake_nxt;
      o_tb_timeout <= tb_timeout_nxt;
    end
  end

endmodule

`default_nettype wire

/* timer_event_counter_time_base_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_checker #(
  parameter logic [7:0] TB_VECTOR = 8'h0c
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_external_count_pin,
  input wire logic i_pin_pullup_enable,
  input wire logic i_alt_clock_tick,
  input wire logic i_power_down,
  input wire logic o_pin_pullup,
  input wire logic o_counter_irq,
  input wire logic o_tb_irq,
  input wire logic [7:0] o_vector_addr,
  input wire logic o_wake,
  input wire logic o_tb_timeout
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_pullup; !$past(i_rst) |-> o_pin_pullup == $past(i_pin_pullup_enable); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-high request lost");
  property p_vec_cnt; o_counter_irq |-> o_vector_addr == 8'h08; endproperty
  a_vec_cnt: assert property (p_vec_cnt) else $error("counter vector wrong");
  property p_vec_tb; o_tb_irq && !o_counter_irq |-> o_vector_addr == TB_VECTOR; endproperty
  a_vec_tb: assert property (p_vec_tb) else $error("time base vector wrong");
  property p_irq_off; i_wr && i_addr == 8'h02 && !i_wdata[0] |-> ##2 !o_counter_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("counter irq while disabled");
  property p_rst; $past(i_rst) |-> o_rdata == 8'h00 && !o_counter_irq && !o_wake; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_wake_pd; o_wake |-> $past(i_power_down); endproperty
  a_wake_pd: assert property (p_wake_pd) else $error("wake outside power-down");
  property p_wake_pulse; o_wake |=> !o_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
  property p_tb_pulse; o_tb_timeout |=> !o_tb_timeout [*8]; endproperty
  a_tb_pulse: assert property (p_tb_pulse) else $error("time base timeouts too close");
  property p_rdata; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data without a read");
endmodule
bind timer_event_counter_time_base timer_checker #(.TB_VECTOR(TB_VECTOR)) i_chk (.i_clk_sys, .i_rst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_external_count_pin, .i_pin_pullup_enable, .i_alt_clock_tick,
  .i_power_down, .o_pin_pullup, .o_counter_irq, .o_tb_irq, .o_vector_addr, .o_wake, .o_tb_timeout);
`default_nettype wire

/* pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic i_clk_sys,
  output logic o_pin
);
  // ****************************************
  // Pin driver
  // ****************************************
  initial o_pin = 1'b0;
  // The pin moves only on an edge, so each level holds long enough for the counter's sampling.
  task automatic set_level(input logic v);
    @(posedge i_clk_sys);
    o_pin <= v;
  endtask
  task automatic pulse();
    set_level(1'b1);
    repeat (4) @(posedge i_clk_sys);
    set_level(1'b0);
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pin_pullup_enable = 1'b0;
  logic i_power_down = 1'b0;
  logic pin, o_pin_pullup, o_counter_irq, o_tb_irq, o_wake, o_tb_timeout;
  logic [7:0] o_rdata, o_vector_addr, rv;
  int fail_count = 0;
  int total_checks = 0;
  int wake_count = 0;
  logic [1:0] tick_div_r = 2'h0;
  logic alt_tick = 1'b0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  // The slow source ticks once in four clocks, so its rate is easy to tell from the system clock.
  always @(posedge i_clk_sys) begin
    tick_div_r <= tick_div_r + 2'h1;
    alt_tick <= (tick_div_r == 2'h3);
  end
  always @(posedge i_clk_sys) if (o_wake === 1'b1) wake_count <= wake_count + 1;
  pin_source i_pin (.i_clk_sys(i_clk_sys), .o_pin(pin));
  timer_event_counter_time_base i_dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_external_count_pin(pin), .i_pin_pullup_enable, .i_alt_clock_tick(alt_tick), .i_power_down,
    .o_pin_pullup, .o_counter_irq, .o_tb_irq, .o_vector_addr, .o_wake, .o_tb_timeout);
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(n, {8'h00, rv}, {8'h00, e});
  endtask
  task automatic t_reset();
    for (int a = 0; a < 5; a++) rc("reg_reset", a[7:0], 8'h00);
    @(posedge i_clk_sys);
    i_pin_pullup_enable <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    chk("pullup", o_pin_pullup, 1'b1);
  endtask
  task automatic t_timer();
    wr(8'h02, 8'h01);
    wr(8'h01, 8'hfd);
    wr(8'h00, 8'h90);
    for (int i = 0; i < 20 && o_counter_irq !== 1'b1; i++) @(posedge i_clk_sys);
    #1 chk("cnt_irq", o_counter_irq, 1'b1);
    chk("vector", o_vector_addr, 8'h08);
    rc("cnt_flag", 8'h02, 8'h03);
    wr(8'h00, 8'h80);
    rd(8'h01, rv);
    chk("reload", rv >= 8'hfd, 1'b1);
    rc("stopped", 8'h01, rv);
  endtask
  task automatic t_event();
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h10);
    for (int g = 0; g < 2; g++) begin
      wr(8'h00, g ? 8'h58 : 8'h50);
      i_pin.set_level(1'b1);
      repeat (5) @(posedge i_clk_sys);
      rc("evt_rise", 8'h01, 8'h11);
      i_pin.set_level(1'b0);
      repeat (5) @(posedge i_clk_sys);
      rc("evt_fall", 8'h01, 8'h11 + 8'(g));
    end
  endtask
  task automatic t_sleep();
    wr(8'h00, 8'h40);
    wr(8'h01, 8'hff);
    wr(8'h00, 8'h50);
    i_power_down <= 1'b1;
    for (int k = 0; k < 2; k++) i_pin.pulse();
    i_power_down <= 1'b0;
    chk("wake", 16'(wake_count), 16'h0001);
    rc("pd_count", 8'h01, 8'hff);
  endtask
  task automatic t_capture();
    wr(8'h00, 8'hc0);
    wr(8'h01, 8'h00);
    i_pin.set_level(1'b1);
    wr(8'h00, 8'hd0);
    i_pin.set_level(1'b0);
    repeat (40) @(posedge i_clk_sys);
    i_pin.set_level(1'b1);
    repeat (8) @(posedge i_clk_sys);
    rc("cap_stop", 8'h00, 8'hc0);
    rd(8'h01, rv);
    chk("cap_len", rv >= 8'd37 && rv <= 8'd45, 1'b1);
    i_pin.pulse();
    rc("cap_idle", 8'h01, rv);
  endtask
  task automatic t_tbase();
    int n;
    wr(8'h02, 8'h04);
    for (int s = 0; s < 2; s++) begin
      wr(8'h03, s[7:0]);
      for (int k = 0; k < 2; k++) begin
        n = 0;
        @(posedge i_clk_sys);
        while (o_tb_timeout !== 1'b1 && n < 5000) begin
          @(posedge i_clk_sys);
          n++;
        end
      end
      chk("tb_period", 16'(n + 1), 16'(1024 << s));
    end
    chk("tb_irq", o_tb_irq, 1'b1);
  endtask
  task automatic t_source();
    int n;
    wr(8'h01, 8'h00);
    wr(8'h00, 8'hb1);
    repeat (80) @(posedge i_clk_sys);
    wr(8'h00, 8'ha1);
    rd(8'h01, rv);
    chk("alt_count", rv >= 8'h0a && rv <= 8'h0b, 1'b1);
    wr(8'h03, 8'h00);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge i_clk_sys);
      while (o_tb_timeout !== 1'b1 && n < 9000) begin
        @(posedge i_clk_sys);
        n++;
      end
    end
    chk("tb_alt_period", 16'(n + 1), 16'h1000);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset();
    $display("reset test done");
    t_timer();
    $display("timer test done");
    t_event();
    $display("event test done");
    t_sleep();
    $display("sleep test done");
    t_capture();
    $display("capture test done");
    t_tbase();
    $display("time base test done");
    t_source();
    $display("clock source test done");
    end_sim();
  end
  // The whole run needs about 14500 cycles, so this limit only trips on a hang.
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
